// File: hw/microstep_torque_params.svh
`ifndef MICROSTEP_TORQUE_PARAMS_SVH
`define MICROSTEP_TORQUE_PARAMS_SVH

// Register offsets
`define OFS_POINT_SEVEN 8'h1D
`define OFS_POINT_EIGHT 8'h1E
`define OFS_COUNT_LOW 8'h1F
`define OFS_COUNT_HIGH 8'h20
`define OFS_INIT_LOW 8'h21
`define OFS_CURRENT_FINAL 8'h22
`define OFS_FINAL_LOW 8'h23

// Field positions (least significant bit of each field)
`define POS_COUNT_HIGH 5
`define POS_RSVD 3
`define POS_LEARN_CURRENT 3

// Reset values
`define RST_POINT 8'h00
`define RST_COUNT 11'h000
`define RST_RSVD 2'h0
`define RST_INIT_PARAM 11'h000
`define RST_FINAL_PARAM 11'h000
`define RST_LEARN_CURRENT 5'h04
`define RST_RDATA 8'h00

// Learning current is the setting times eight
`define LEARN_CURRENT_SHIFT 3

// Samples averaged per count update, as a power of two
`define AVG_LOG2 2

`endif

// File: hw/torque_regs_pkg.sv
package torque_regs_pkg;

  typedef logic [10:0] count_t;
  typedef logic [7:0] byte_t;

  typedef enum logic [1:0] {
    LEARN_IDLE,
    LEARN_INITIAL,
    LEARN_FINAL,
    LEARN_FINISH
  } learn_state_t;

endpackage

// File: hw/torque_sample_if.sv
`timescale 1ns/10ps

interface torque_sample_if;
  import torque_regs_pkg::*;

  logic sample_valid;
  count_t sample;
  count_t count;
  logic count_update;

  modport source (
    output sample_valid,
    output sample,
    input count,
    input count_update
  );

  modport filter (
    input sample_valid,
    input sample,
    output count,
    output count_update
  );
endinterface

// File: hw/load_torque_filter.sv
`timescale 1ns/10ps
`include "microstep_torque_params.svh"

// Box average of load samples; a mean of samples keeps the count
// proportional to the load while removing ripple of the current loop.
module load_torque_filter
  import torque_regs_pkg::*;
#(
  parameter int AVG_LOG2 = `AVG_LOG2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Sample stream in, averaged count out
  torque_sample_if.filter tq
);

  localparam int ACC_W = 11 + AVG_LOG2;

  logic [ACC_W-1:0] acc;
  logic [AVG_LOG2-1:0] fill;
  logic last_sample;
  logic [ACC_W-1:0] sum;

  assign last_sample = tq.sample_valid && (fill == {AVG_LOG2{1'b1}});
  assign sum = acc + ACC_W'(tq.sample);

  always_ff @(posedge clk) begin
    if (rst) begin
      acc <= '0;
      fill <= '0;
    end else if (tq.sample_valid) begin
      acc <= last_sample ? '0 : sum;
      fill <= fill + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tq.count <= `RST_COUNT;
      tq.count_update <= 1'b0;
    end else begin
      tq.count_update <= last_sample;
      if (last_sample) begin
        tq.count <= sum[ACC_W-1:AVG_LOG2];
      end
    end
  end

endmodule

// File: hw/microstep_torque_regs.sv
`timescale 1ns/10ps
`include "microstep_torque_params.svh"

// Notes on behaviour
// - Register at 0x1D holds table point seven level, read/write, resets to zero.
// - Register at 0x1E holds table point eight level, read/write, resets to zero.
// - Register at 0x1F reads low eight bits of load torque count.
// - Load torque count rises and falls in proportion to motor load.
// - Bits 7-5 at 0x20 read the upper three count bits.
// - Initial level learn parameter: high bits 0x20[2:0], low byte 0x21.
// - Initial learning current is eight times setting in 0x22[7:3], reset 4.
// - Final level learn parameter upper bits sit in 0x22[2:0].
// - Final level learn parameter low byte sits at 0x23, resets to zero.
// - Table points are applied only while the custom table enable is one.
// - Learning starts on the start bit and the bit clears when learning ends.
module microstep_torque_regs
  import torque_regs_pkg::*;
#(
  parameter int AVG_LOG2 = `AVG_LOG2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,

  // Register port from the serial interface
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output byte_t reg_rdata,
  output logic reg_rvalid,

  // Load measurement from the current regulator
  input wire logic [10:0] load_metric,
  input wire logic load_metric_valid,
  output count_t load_torque_count,

  // Custom microstep table
  input wire logic custom_table_enable,
  output byte_t table_point_seven_level,
  output byte_t table_point_eight_level,

  // Auto-torque learning
  input wire logic learning_start_bit,
  input wire logic learn_step_done,
  output logic learning_start_clear,
  output logic learning_active,
  output logic learning_at_final,
  output byte_t initial_learning_current,
  output count_t initial_level_learn_param,
  output count_t final_level_learn_param
);

  localparam int POINTS = 2;

  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] ofs);
    addr_hit = (addr == ofs);
  endfunction

  // Load torque averaging
  torque_sample_if tq ();

  assign tq.sample_valid = load_metric_valid;
  assign tq.sample = load_metric;

  load_torque_filter #(
    .AVG_LOG2(AVG_LOG2)
  ) u_filter (
    .clk(clk),
    .rst(rst),
    .tq(tq)
  );

  assign load_torque_count = tq.count;

  // Address decode
  logic sel_seven;
  logic sel_eight;
  logic sel_count_low;
  logic sel_count_high;
  logic sel_init_low;
  logic sel_current_final;
  logic sel_final_low;

  assign sel_seven = addr_hit(reg_addr, `OFS_POINT_SEVEN);
  assign sel_eight = addr_hit(reg_addr, `OFS_POINT_EIGHT);
  assign sel_count_low = addr_hit(reg_addr, `OFS_COUNT_LOW);
  assign sel_count_high = addr_hit(reg_addr, `OFS_COUNT_HIGH);
  assign sel_init_low = addr_hit(reg_addr, `OFS_INIT_LOW);
  assign sel_current_final = addr_hit(reg_addr, `OFS_CURRENT_FINAL);
  assign sel_final_low = addr_hit(reg_addr, `OFS_FINAL_LOW);

  // Write strobes
  logic [POINTS-1:0] we_point;
  logic we_count_high;
  logic we_init_low;
  logic we_current_final;
  logic we_final_low;

  assign we_point[0] = reg_write && sel_seven;
  assign we_point[1] = reg_write && sel_eight;
  assign we_count_high = reg_write && sel_count_high;
  assign we_init_low = reg_write && sel_init_low;
  assign we_current_final = reg_write && sel_current_final;
  assign we_final_low = reg_write && sel_final_low;

  // Custom table points
  byte_t point [POINTS];

  genvar gi;
  generate
    for (gi = 0; gi < POINTS; gi++) begin : g_point
      always_ff @(posedge clk) begin
        if (rst) begin
          point[gi] <= `RST_POINT;
        end else if (we_point[gi]) begin
          point[gi] <= reg_wdata;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst) begin
      table_point_seven_level <= `RST_POINT;
      table_point_eight_level <= `RST_POINT;
    end else begin
      table_point_seven_level <= custom_table_enable ? point[0] : `RST_POINT;
      table_point_eight_level <= custom_table_enable ? point[1] : `RST_POINT;
    end
  end

  // Reserved bits of 0x20 keep what the host writes
  logic [1:0] rsvd_bits;

  always_ff @(posedge clk) begin
    if (rst) begin
      rsvd_bits <= `RST_RSVD;
    end else if (we_count_high) begin
      rsvd_bits <= reg_wdata[`POS_RSVD+1:`POS_RSVD];
    end
  end

  // Learning current setting
  logic [4:0] learn_current_setting;

  always_ff @(posedge clk) begin
    if (rst) begin
      learn_current_setting <= `RST_LEARN_CURRENT;
    end else if (we_current_final) begin
      learn_current_setting <= reg_wdata[7:`POS_LEARN_CURRENT];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      initial_learning_current <= byte_t'({`RST_LEARN_CURRENT, 3'h0});
    end else begin
      initial_learning_current <= byte_t'({learn_current_setting, 3'h0});
    end
  end

  // Learning sequencer
  learn_state_t state;
  learn_state_t next_state;
  logic capture_initial;
  logic capture_final;

  assign capture_initial = (state == LEARN_INITIAL) && learn_step_done;
  assign capture_final = (state == LEARN_FINAL) && learn_step_done;

  always_comb begin
    next_state = state;
    case (state)
      LEARN_IDLE: begin
        if (learning_start_bit) begin
          next_state = LEARN_INITIAL;
        end
      end
      LEARN_INITIAL: begin
        if (learn_step_done) begin
          next_state = LEARN_FINAL;
        end
      end
      LEARN_FINAL: begin
        if (learn_step_done) begin
          next_state = LEARN_FINISH;
        end
      end
      LEARN_FINISH: begin
        if (!learning_start_bit) begin
          next_state = LEARN_IDLE;
        end
      end
      default: begin
        next_state = LEARN_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= LEARN_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      learning_start_clear <= 1'b0;
    end else begin
      learning_start_clear <= capture_final;
    end
  end

  assign learning_active = (state == LEARN_INITIAL) || (state == LEARN_FINAL);
  assign learning_at_final = (state == LEARN_FINAL);

  // Learned parameters; a capture wins over a host write in the same cycle
  // so a finished measurement is never lost.
  // initial level parameter
  always_ff @(posedge clk) begin
    if (rst) begin
      initial_level_learn_param <= `RST_INIT_PARAM;
    end else if (capture_initial) begin
      initial_level_learn_param <= tq.count;
    end else begin
      if (we_count_high) begin
        initial_level_learn_param[10:8] <= reg_wdata[2:0];
      end
      if (we_init_low) begin
        initial_level_learn_param[7:0] <= reg_wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      final_level_learn_param <= `RST_FINAL_PARAM;
    end else if (capture_final) begin
      final_level_learn_param <= tq.count;
    end else begin
      if (we_current_final) begin
        final_level_learn_param[10:8] <= reg_wdata[2:0];
      end
      if (we_final_low) begin
        final_level_learn_param[7:0] <= reg_wdata;
      end
    end
  end

  // Read data select
  byte_t next_rdata;

  always_comb begin
    next_rdata = `RST_RDATA;
    case (1'b1)
      sel_seven: next_rdata = point[0];
      sel_eight: next_rdata = point[1];
      sel_count_low: next_rdata = tq.count[7:0];
      sel_count_high: begin
        next_rdata = {tq.count[10:8], rsvd_bits, initial_level_learn_param[10:8]};
      end
      sel_init_low: next_rdata = initial_level_learn_param[7:0];
      sel_current_final: begin
        next_rdata = {learn_current_setting, final_level_learn_param[10:8]};
      end
      sel_final_low: next_rdata = final_level_learn_param[7:0];
      default: next_rdata = `RST_RDATA;
    endcase
  end

  // Read data is sampled at the strobe so a count update right after it
  // cannot tear the byte already handed to the serial port.
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= `RST_RDATA;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_read;
      if (reg_read) begin
        reg_rdata <= next_rdata;
      end
    end
  end

endmodule

// File: dv/torque_regs_sva.sv
`timescale 1ns/10ps
module torque_regs_sva
  import torque_regs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire byte_t reg_rdata,
  input wire logic reg_rvalid,
  // Count, table and learning
  input wire count_t load_torque_count,
  input wire logic custom_table_enable,
  input wire byte_t table_point_seven_level,
  input wire byte_t table_point_eight_level,
  input wire logic learn_step_done,
  input wire logic learning_start_clear,
  input wire logic learning_active,
  input wire logic learning_at_final,
  input wire byte_t initial_learning_current,
  input wire count_t initial_level_learn_param,
  input wire count_t final_level_learn_param
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire rd_unmapped = reg_read && (reg_addr < 8'h1D || reg_addr > 8'h23);
  wire in_initial = learning_active && !learning_at_final;
  a_rvalid_after_read: assert property (reg_read |=> reg_rvalid)
    else $error("read not answered");
  a_rvalid_no_cause: assert property (reg_rvalid |-> $past(reg_read))
    else $error("answer without read");
  a_point_seven_back: assert property (reg_write && reg_addr == 8'h1D ##2
    reg_read && reg_addr == 8'h1D |=> reg_rdata == $past(reg_wdata, 3))
    else $error("point seven readback wrong");
  a_count_low_read: assert property (reg_read && reg_addr == 8'h1F
    |=> reg_rdata == $past(load_torque_count[7:0]))
    else $error("count low byte wrong");
  a_count_high_read: assert property (reg_read && reg_addr == 8'h20
    |=> reg_rdata[7:5] == $past(load_torque_count[10:8]))
    else $error("count high bits wrong");
  a_unmapped_zero: assert property (rd_unmapped |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_table_gated_off: assert property (!custom_table_enable
    |=> table_point_seven_level == 8'h00 && table_point_eight_level == 8'h00)
    else $error("table output while disabled");
  a_learn_current_x8: assert property (reg_write && reg_addr == 8'h22
    |-> ##2 initial_learning_current == {$past(reg_wdata[7:3], 2), 3'h0})
    else $error("learning current not eight times setting");
  a_initial_capture: assert property (in_initial && learn_step_done
    |=> initial_level_learn_param == $past(load_torque_count) && learning_at_final)
    else $error("initial capture wrong");
  a_final_capture: assert property (learning_at_final && learn_step_done
    |=> final_level_learn_param == $past(load_torque_count))
    else $error("final capture wrong");
  a_start_bit_clear: assert property (learning_at_final && learn_step_done
    |=> learning_start_clear && !learning_active ##1 !learning_start_clear)
    else $error("start clear pulse wrong");
  c_learn_done: cover property (learning_start_clear);
  c_table_on: cover property (custom_table_enable && table_point_seven_level != 8'h00);
  c_unmapped: cover property (rd_unmapped);
endmodule

bind microstep_torque_regs torque_regs_sva torque_regs_sva_i (
  .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .load_torque_count(load_torque_count),
  .custom_table_enable(custom_table_enable),
  .table_point_seven_level(table_point_seven_level),
  .table_point_eight_level(table_point_eight_level),
  .learn_step_done(learn_step_done), .learning_start_clear(learning_start_clear),
  .learning_active(learning_active), .learning_at_final(learning_at_final),
  .initial_learning_current(initial_learning_current),
  .initial_level_learn_param(initial_level_learn_param),
  .final_level_learn_param(final_level_learn_param)
);

// File: dv/host_side_model.sv
`timescale 1ns/10ps
module host_side_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Start request and device clear
  input wire logic go,
  input wire logic learning_start_clear,
  output logic learning_start_bit
);
  always_ff @(posedge clk) begin
    if (rst || learning_start_clear) begin
      learning_start_bit <= 1'b0;
    end else if (go) begin
      learning_start_bit <= 1'b1;
    end
  end
endmodule

// File: dv/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import torque_regs_pkg::*;
  logic clk, rst, reg_write, reg_read, load_metric_valid, custom_table_enable;
  logic learn_step_done, go, reg_rvalid, learning_start_bit, learning_start_clear;
  logic learning_active, learning_at_final;
  logic [7:0] reg_addr, reg_wdata;
  logic [10:0] load_metric;
  byte_t reg_rdata, table_point_seven_level, table_point_eight_level;
  byte_t initial_learning_current;
  count_t load_torque_count, initial_level_learn_param, final_level_learn_param;
  int bad_count, checked, cycles;
  microstep_torque_regs microstep_torque_regs_i (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .load_metric(load_metric),
    .load_metric_valid(load_metric_valid), .load_torque_count(load_torque_count),
    .custom_table_enable(custom_table_enable),
    .table_point_seven_level(table_point_seven_level),
    .table_point_eight_level(table_point_eight_level),
    .learning_start_bit(learning_start_bit), .learn_step_done(learn_step_done),
    .learning_start_clear(learning_start_clear), .learning_active(learning_active),
    .learning_at_final(learning_at_final),
    .initial_learning_current(initial_learning_current),
    .initial_level_learn_param(initial_level_learn_param),
    .final_level_learn_param(final_level_learn_param)
  );
  host_side_model host_side_model_i (
    .clk(clk), .rst(rst), .go(go), .learning_start_clear(learning_start_clear),
    .learning_start_bit(learning_start_bit)
  );
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  // Hang guard, well above the fewer than one hundred cycles needed
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      summarize();
    end
  end
  task summarize;
    $display("mismatches %0d comparisons %0d", bad_count, checked);
    if (bad_count == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task step;
    @(posedge clk);
    #1;
  endtask
  task chk(input logic [10:0] got, input logic [10:0] exp);
    checked++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      bad_count++;
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    step;
    reg_write = 1;
    reg_addr = a;
    reg_wdata = d;
    step;
    reg_write = 0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] exp);
    step;
    reg_read = 1;
    reg_addr = a;
    step;
    reg_read = 0;
    chk(11'(reg_rvalid), 11'h001);
    chk(11'(reg_rdata), 11'(exp));
  endtask
  // Four samples a, a+b, a+2b, a+3b back to back
  task send(input logic [10:0] a, input logic [10:0] b);
    for (int i = 0; i < 4; i++) begin
      step;
      load_metric_valid = 1;
      load_metric = a + 11'(i) * b;
    end
    step;
    load_metric_valid = 0;
    step;
  endtask
  task pulse_done;
    step;
    learn_step_done = 1;
    step;
    learn_step_done = 0;
  endtask
  task t_reset;
    rd(8'h1D, 8'h00);
    rd(8'h1E, 8'h00);
    rd(8'h1F, 8'h00);
    rd(8'h20, 8'h00);
    rd(8'h21, 8'h00);
    rd(8'h22, 8'h20);
    rd(8'h23, 8'h00);
    chk(11'(initial_learning_current), 11'h020);
  endtask
  task t_regs;
    wr(8'h1D, 8'hA5);
    rd(8'h1D, 8'hA5);
    wr(8'h1E, 8'h5A);
    rd(8'h1E, 8'h5A);
    wr(8'h1F, 8'hFF);
    rd(8'h1F, 8'h00);
    wr(8'h20, 8'hFF);
    rd(8'h20, 8'h1F);
    wr(8'h21, 8'h3C);
    wr(8'h22, 8'hFF);
    wr(8'h23, 8'hC3);
    rd(8'h22, 8'hFF);
    rd(8'h23, 8'hC3);
    chk(11'(initial_learning_current), 11'h0F8);
    chk(initial_level_learn_param, 11'h73C);
    chk(final_level_learn_param, 11'h7C3);
    wr(8'h30, 8'hFF);
    rd(8'h30, 8'h00);
    rd(8'h1C, 8'h00);
  endtask
  task t_table;
    chk(11'(table_point_seven_level), 11'h000);
    custom_table_enable = 1;
    step;
    chk(11'(table_point_seven_level), 11'h0A5);
    chk(11'(table_point_eight_level), 11'h05A);
  endtask
  task t_load;
    send(11'h100, 11'h100);
    chk(load_torque_count, 11'h280);
    rd(8'h1F, 8'h80);
    rd(8'h20, 8'h5F);
    send(11'h7FF, 11'h000);
    chk(load_torque_count, 11'h7FF);
  endtask
  task t_learn;
    step;
    go = 1;
    step;
    go = 0;
    for (int i = 0; i < 5 && !learning_active; i++) step;
    chk(11'(learning_active), 11'h001);
    pulse_done;
    chk(initial_level_learn_param, 11'h7FF);
    chk(11'(learning_at_final), 11'h001);
    send(11'h100, 11'h100);
    pulse_done;
    chk(final_level_learn_param, 11'h280);
    chk(11'(learning_start_clear), 11'h001);
    chk(11'(learning_active), 11'h000);
    step;
    chk(11'(learning_start_bit), 11'h000);
    rd(8'h23, 8'h80);
    rd(8'h22, 8'hFA);
    rd(8'h21, 8'hFF);
  endtask
  initial begin
    rst = 1;
    {reg_write, reg_read, load_metric_valid, custom_table_enable} = 4'h0;
    {learn_step_done, go, reg_addr, reg_wdata, load_metric} = 29'h0;
    step;
    step;
    rst = 0;
    t_reset;
    t_regs;
    t_table;
    t_load;
    t_learn;
    summarize();
  end
endmodule
